// *** rtl/shic_pkg.sv ***
package shic_pkg;

	// ========================================================
	// Register port
	localparam int unsigned SHIC_DATA_W = 8;
	localparam int unsigned SHIC_ADDR_W = 4;
	localparam logic [SHIC_ADDR_W-1:0] SHIC_SAVE_CTL_OFF = 4'h0;
	localparam logic [SHIC_ADDR_W-1:0] SHIC_MODE_SEL_OFF = 4'h1;
	localparam logic [SHIC_ADDR_W-1:0] SHIC_STAT_OFF = 4'h2;

	// ========================================================
	// Field layout
	localparam int unsigned SHIC_WDT_MASK_BIT = 6;
	localparam int unsigned SHIC_PIN_MASK_BIT = 5;
	localparam int unsigned SHIC_INT_MASK_BIT = 4;
	localparam int unsigned SHIC_STANDBY_BIT = 1;
	localparam int unsigned SHIC_SEL_HI_BIT = 1;
	localparam int unsigned SHIC_SEL_LO_BIT = 0;
	localparam int unsigned SHIC_STAT_HALT_BIT = 0;
	localparam int unsigned SHIC_STAT_IDLE_BIT = 1;
	localparam int unsigned SHIC_STAT_CPU_BIT = 2;
	localparam int unsigned SHIC_STAT_PERIPH_BIT = 3;

	// ========================================================
	// Reset values and encodings
	localparam logic [SHIC_DATA_W-1:0] SHIC_REG_RST = 8'h00;
	localparam logic [1:0] SHIC_SEL_IDLE1 = 2'h0;
	localparam logic [1:0] SHIC_SEL_RST = 2'h0;
	localparam int unsigned SHIC_EXT_W = 15;
	localparam int unsigned SHIC_PRIO_W = 3;

	// ========================================================
	// Types
	typedef enum logic [1:0] {
		SHIC_NORMAL,
		SHIC_HALT,
		SHIC_IDLE1
	} shic_mode_t;

	typedef struct packed {
		logic watchdog_wake_mask;
		logic pin_nonmaskable_wake_mask;
		logic maskable_wake_mask;
	} shic_masks_t;

	typedef struct packed {
		logic nmi_pin;
		logic watchdog_interrupt;
		logic [SHIC_EXT_W-1:0] external_interrupt_pins;
		logic periph_int_req;
		logic [SHIC_PRIO_W-1:0] int_req_prio;
	} shic_wake_src_t;

	typedef struct packed {
		logic in_service;
		logic [SHIC_PRIO_W-1:0] service_prio;
		logic interrupts_enabled_state;
	} shic_isr_t;

	typedef struct packed {
		logic pin;
		logic watchdog_reset;
		logic power_on_clear;
		logic low_voltage_detector;
		logic clock_monitor;
	} shic_rst_src_t;

	typedef struct packed {
		logic wake;
		logic by_nmi;
		logic ack_maskable;
		logic resume_next;
		logic reset_req;
	} shic_decision_t;

	typedef struct packed {
		logic cpu;
		logic periph;
		logic sub_ext_periph;
		logic general_timer_m;
		logic watch_timer;
		logic main_osc;
		logic pll;
		logic flash;
	} shic_clk_en_t;

endpackage : shic_pkg

// *** rtl/shic_wake_eval.sv ***
`timescale 1ns/1ps
module shic_wake_eval
	import shic_pkg::*;
(
	input wire shic_mode_t mode,
	input wire shic_masks_t masks,
	input wire shic_wake_src_t src,
	input wire shic_isr_t isr,
	input wire shic_rst_src_t rst_src,
	output shic_decision_t dec
);

	logic standby;
	logic in_halt;
	logic nmi_ok;
	logic mask_req;
	logic mask_ok;
	logic rst_any;
	logic higher;

	always_comb begin
		in_halt = (mode == SHIC_HALT);
		standby = (mode != SHIC_NORMAL);
		rst_any = |rst_src;
		mask_req = (|src.external_interrupt_pins) | src.periph_int_req;
		// Halt ignores the wake masks; idle-1 honours them
		if (in_halt) begin
			nmi_ok = src.nmi_pin | src.watchdog_interrupt;
			mask_ok = mask_req;
		end else begin
			nmi_ok = (src.nmi_pin & ~masks.pin_nonmaskable_wake_mask)
				| (src.watchdog_interrupt & ~masks.watchdog_wake_mask);
			mask_ok = mask_req & ~masks.maskable_wake_mask;
		end
		// Smaller code means higher priority
		higher = ~isr.in_service | (src.int_req_prio < isr.service_prio);
		dec.wake = standby & (nmi_ok | mask_ok | rst_any);
		dec.by_nmi = standby & ~rst_any & nmi_ok;
		dec.ack_maskable = standby & ~rst_any & ~nmi_ok & mask_ok
			& isr.interrupts_enabled_state & higher;
		dec.resume_next = standby & ~rst_any & ~nmi_ok & mask_ok & ~dec.ack_maskable;
		dec.reset_req = rst_any;
	end

endmodule : shic_wake_eval

// *** rtl/shic_top.sv ***
`timescale 1ns/1ps
module shic_top
	import shic_pkg::*;
(
	input wire sys_clk,
	input wire reset,
	input wire [SHIC_ADDR_W-1:0] reg_addr,
	input wire [SHIC_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output logic [SHIC_DATA_W-1:0] reg_rdata,
	input wire halt_instr,
	input wire shic_wake_src_t wake_src,
	input wire shic_isr_t isr,
	input wire shic_rst_src_t rst_src,
	input wire subclock_fitted,
	input wire tmr_m_sel_subclock,
	input wire watch_sel_baud_divider,
	output shic_clk_en_t clk_en,
	output logic port_hold,
	output logic data_retain,
	output logic ack_nmi,
	output logic ack_maskable,
	output logic resume_next,
	output logic sys_reset_req,
	output logic in_halt,
	output logic in_idle1
);

	// ========================================================
	// State
	typedef struct packed {
		shic_mode_t mode;
		shic_masks_t masks;
		logic standby_request_bit;
		logic [1:0] power_mode_sel;
		logic [SHIC_DATA_W-1:0] rdata;
		shic_clk_en_t clk_en;
		logic port_hold;
		logic data_retain;
		logic ack_nmi;
		logic ack_maskable;
		logic resume_next;
		logic sys_reset_req;
		logic in_halt;
		logic in_idle1;
	} shic_state_t;

	shic_state_t state_r;
	shic_state_t state_nxt;
	shic_decision_t dec;
	logic save_ctl_wr;
	logic idle_entry;

	// ========================================================
	// Functions
	function automatic shic_clk_en_t shic_clk_for(input shic_mode_t m, input logic sub_fit,
		input logic tm_sub, input logic wt_baud);
		shic_clk_en_t c;
		c.main_osc = 1'b1;
		c.pll = 1'b1;
		c.flash = 1'b1;
		c.sub_ext_periph = 1'b1;
		case (m)
			SHIC_HALT: begin
				c.cpu = 1'b0;
				c.periph = 1'b1;
				c.general_timer_m = sub_fit | ~tm_sub;
				c.watch_timer = sub_fit | wt_baud;
			end
			SHIC_IDLE1: begin
				c.cpu = 1'b0;
				c.periph = 1'b0;
				c.general_timer_m = sub_fit & tm_sub;
				c.watch_timer = sub_fit | wt_baud;
			end
			default: begin
				c.cpu = 1'b1;
				c.periph = 1'b1;
				c.general_timer_m = 1'b1;
				c.watch_timer = 1'b1;
			end
		endcase
		return c;
	endfunction : shic_clk_for

	function automatic logic [SHIC_DATA_W-1:0] shic_read(input shic_state_t s, input logic [SHIC_ADDR_W-1:0] a);
		logic [SHIC_DATA_W-1:0] v;
		v = SHIC_REG_RST;
		case (a)
			SHIC_SAVE_CTL_OFF: begin
				v[SHIC_WDT_MASK_BIT] = s.masks.watchdog_wake_mask;
				v[SHIC_PIN_MASK_BIT] = s.masks.pin_nonmaskable_wake_mask;
				v[SHIC_INT_MASK_BIT] = s.masks.maskable_wake_mask;
				v[SHIC_STANDBY_BIT] = s.standby_request_bit;
			end
			SHIC_MODE_SEL_OFF: begin
				v[SHIC_SEL_HI_BIT] = s.power_mode_sel[1];
				v[SHIC_SEL_LO_BIT] = s.power_mode_sel[0];
			end
			SHIC_STAT_OFF: begin
				v[SHIC_STAT_HALT_BIT] = s.in_halt;
				v[SHIC_STAT_IDLE_BIT] = s.in_idle1;
				v[SHIC_STAT_CPU_BIT] = s.clk_en.cpu;
				v[SHIC_STAT_PERIPH_BIT] = s.clk_en.periph;
			end
			default: v = SHIC_REG_RST;
		endcase
		return v;
	endfunction : shic_read

	// ========================================================
	// Wake evaluation
	shic_wake_eval u_wake_eval (
		.mode(state_r.mode),
		.masks(state_r.masks),
		.src(wake_src),
		.isr(isr),
		.rst_src(rst_src),
		.dec(dec)
	);

	// ========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		save_ctl_wr = reg_wr & (reg_addr == SHIC_SAVE_CTL_OFF);
		idle_entry = (state_r.mode == SHIC_NORMAL) & state_r.standby_request_bit
			& (state_r.power_mode_sel == SHIC_SEL_IDLE1);
		state_nxt.ack_nmi = 1'b0;
		state_nxt.ack_maskable = 1'b0;
		state_nxt.resume_next = 1'b0;
		state_nxt.sys_reset_req = dec.reset_req;
		state_nxt.rdata = reg_rd ? shic_read(state_r, reg_addr) : SHIC_REG_RST;
		if (reg_wr & (reg_addr == SHIC_MODE_SEL_OFF)) begin
			state_nxt.power_mode_sel = {reg_wdata[SHIC_SEL_HI_BIT], reg_wdata[SHIC_SEL_LO_BIT]};
		end
		case (state_r.mode)
			SHIC_NORMAL: begin
				if (idle_entry) begin
					state_nxt.mode = SHIC_IDLE1;
				end else if (state_r.standby_request_bit) begin
					// Other standby modes are not served here
					state_nxt.standby_request_bit = 1'b0;
				end else if (halt_instr) begin
					state_nxt.mode = SHIC_HALT;
				end
			end
			SHIC_HALT, SHIC_IDLE1: begin
				if (dec.wake) begin
					state_nxt.mode = SHIC_NORMAL;
					state_nxt.standby_request_bit = 1'b0;
					state_nxt.ack_nmi = dec.by_nmi;
					state_nxt.ack_maskable = dec.ack_maskable;
					state_nxt.resume_next = dec.resume_next;
				end
			end
			default: state_nxt.mode = SHIC_NORMAL;
		endcase
		// Software write wins over the automatic clear
		if (save_ctl_wr) begin
			state_nxt.standby_request_bit = reg_wdata[SHIC_STANDBY_BIT];
			// Masks written together with the standby request are ignored
			if (!reg_wdata[SHIC_STANDBY_BIT]) begin
				state_nxt.masks.watchdog_wake_mask = reg_wdata[SHIC_WDT_MASK_BIT];
				state_nxt.masks.pin_nonmaskable_wake_mask = reg_wdata[SHIC_PIN_MASK_BIT];
				state_nxt.masks.maskable_wake_mask = reg_wdata[SHIC_INT_MASK_BIT];
			end
		end
		state_nxt.clk_en = shic_clk_for(state_nxt.mode, subclock_fitted, tmr_m_sel_subclock,
			watch_sel_baud_divider);
		state_nxt.port_hold = (state_nxt.mode != SHIC_NORMAL);
		state_nxt.data_retain = (state_nxt.mode != SHIC_NORMAL);
		state_nxt.in_halt = (state_nxt.mode == SHIC_HALT);
		state_nxt.in_idle1 = (state_nxt.mode == SHIC_IDLE1);
	end

	// ========================================================
	// Registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= '0;
			state_r.mode <= SHIC_NORMAL;
			state_r.power_mode_sel <= SHIC_SEL_RST;
			state_r.rdata <= SHIC_REG_RST;
			state_r.clk_en <= '1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata = state_r.rdata;
	assign clk_en = state_r.clk_en;
	assign port_hold = state_r.port_hold;
	assign data_retain = state_r.data_retain;
	assign ack_nmi = state_r.ack_nmi;
	assign ack_maskable = state_r.ack_maskable;
	assign resume_next = state_r.resume_next;
	assign sys_reset_req = state_r.sys_reset_req;
	assign in_halt = state_r.in_halt;
	assign in_idle1 = state_r.in_idle1;

	// ========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	logic mask_req_c;
	logic rst_any_c;
	assign mask_req_c = (|wake_src.external_interrupt_pins) | wake_src.periph_int_req;
	assign rst_any_c = |rst_src;

	halt_entry_a: assert property ((state_r.mode == SHIC_NORMAL) && halt_instr && !state_r.standby_request_bit
		|=> in_halt && !clk_en.cpu && clk_en.periph)
		else $error("halt entry wrong");
	halt_nomask_a: assert property (in_halt && wake_src.nmi_pin && !rst_any_c
		|=> !in_halt && ack_nmi && clk_en.cpu)
		else $error("masked halt wake");
	idle_mask_a: assert property (in_idle1 && !rst_any_c && !save_ctl_wr
		&& !(wake_src.nmi_pin && !state_r.masks.pin_nonmaskable_wake_mask)
		&& !(wake_src.watchdog_interrupt && !state_r.masks.watchdog_wake_mask)
		&& !(mask_req_c && !state_r.masks.maskable_wake_mask) |=> in_idle1)
		else $error("masked source woke idle");
	idle_entry_a: assert property (idle_entry |=> in_idle1 && !clk_en.cpu && !clk_en.periph && clk_en.pll
		&& clk_en.main_osc && clk_en.flash)
		else $error("idle-1 entry wrong");
	idle_exit_a: assert property (in_idle1 && dec.wake && !save_ctl_wr |=> !in_idle1 && clk_en.cpu
		&& !state_r.standby_request_bit && !in_halt)
		else $error("idle-1 exit wrong");
	low_prio_a: assert property (in_halt && mask_req_c && !wake_src.nmi_pin && !wake_src.watchdog_interrupt
		&& !rst_any_c && isr.in_service && (wake_src.int_req_prio >= isr.service_prio)
		|=> resume_next && !ack_maskable && !in_halt)
		else $error("low priority acknowledged");
	nmi_branch_a: assert property ($rose(ack_nmi) |-> !resume_next && !ack_maskable
		&& $past(state_r.mode != SHIC_NORMAL))
		else $error("nmi wake wrong");
	di_resume_a: assert property (in_halt && mask_req_c && !isr.interrupts_enabled_state && !rst_any_c
		&& !wake_src.nmi_pin && !wake_src.watchdog_interrupt |=> resume_next && !ack_maskable)
		else $error("disabled wake branched");
	hold_port_a: assert property ((in_halt || in_idle1) |-> port_hold && data_retain)
		else $error("ports not held");
	reset_req_a: assert property (rst_any_c |=> sys_reset_req)
		else $error("reset not forwarded");
	timer_m_a: assert property (in_halt && $past(in_halt) && !$past(subclock_fitted) && $past(tmr_m_sel_subclock)
		|-> !clk_en.general_timer_m)
		else $error("timer m clock wrong");
	watch_a: assert property (in_halt && $past(in_halt) && !$past(subclock_fitted) && $past(watch_sel_baud_divider)
		|-> clk_en.watch_timer)
		else $error("watch timer clock wrong");
	halt_any_a: assert property (in_halt && (mask_req_c || wake_src.watchdog_interrupt) |=> !in_halt)
		else $error("halt not left");
	hi_prio_a: assert property (in_halt && mask_req_c && !wake_src.nmi_pin && !wake_src.watchdog_interrupt
		&& !rst_any_c && isr.interrupts_enabled_state && isr.in_service && (wake_src.int_req_prio < isr.service_prio)
		|=> ack_maskable && !resume_next && !in_halt)
		else $error("high priority not acknowledged");
	reset_wake_a: assert property ((in_halt || in_idle1) && rst_any_c |=> !in_halt && !in_idle1 && sys_reset_req
		&& !ack_nmi && !ack_maskable && !resume_next)
		else $error("reset wake wrong");
	idle_pend_a: assert property (in_idle1 && mask_req_c && !state_r.masks.maskable_wake_mask && !rst_any_c
		|=> !in_idle1 && (ack_nmi || ack_maskable || resume_next))
		else $error("pending request kept idle");
	idle_wdt_a: assert property (in_idle1 && wake_src.watchdog_interrupt && !state_r.masks.watchdog_wake_mask
		&& !rst_any_c |=> !in_idle1 && ack_nmi)
		else $error("watchdog did not wake idle");
	clk_back_a: assert property ((in_halt || in_idle1) && dec.wake |=> clk_en.cpu && clk_en.periph
		&& !port_hold && !data_retain)
		else $error("clocks not restored");
	other_mode_a: assert property ((state_r.mode == SHIC_NORMAL) && state_r.standby_request_bit
		&& (state_r.power_mode_sel != SHIC_SEL_IDLE1) && !save_ctl_wr |=> !in_idle1 && !in_halt
		&& !state_r.standby_request_bit)
		else $error("unbuilt standby entered");
	read_idle_a: assert property (!$past(reg_rd) |-> (reg_rdata == SHIC_REG_RST))
		else $error("read data outside read");

	halt_wake_c: cover property (in_halt ##1 !in_halt && ack_maskable);
	idle_wake_c: cover property (in_idle1 ##1 ack_nmi);
	idle_pend_c: cover property (idle_entry && mask_req_c ##1 in_idle1 ##1 !in_idle1);
	halt_reset_c: cover property (in_halt && rst_any_c ##1 sys_reset_req);
	idle_mask_c: cover property (in_idle1 && wake_src.watchdog_interrupt && state_r.masks.watchdog_wake_mask ##1 in_idle1);

endmodule : shic_top

// *** verification/shic_partner.sv ***
`timescale 1ns/1ps
// ========================================================
// Wake source and interrupt controller model
module shic_partner
	import shic_pkg::*;
(
	input wire sys_clk,
	input wire reset,
	input wire go,
	input wire [1:0] delay,
	input wire shic_wake_src_t want_src,
	input wire shic_rst_src_t want_rst,
	input wire woke,
	output shic_wake_src_t wake_src,
	output shic_rst_src_t rst_src
);
	logic [1:0] cnt_r;
	logic armed_r;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			armed_r <= 1'b0;
			cnt_r <= 2'h0;
			wake_src <= '0;
			rst_src <= '0;
		end else begin
			// Reset sources are single-cycle pulses
			rst_src <= '0;
			if (go) begin
				armed_r <= 1'b1;
				cnt_r <= delay;
			end else if (armed_r && cnt_r == 2'h0) begin
				armed_r <= 1'b0;
				wake_src <= want_src;
				rst_src <= want_rst;
			end else if (armed_r) begin
				cnt_r <= cnt_r - 2'h1;
			end else if (woke) begin
				// Requests stay up until a wake is taken
				wake_src <= '0;
			end
		end
	end
endmodule : shic_partner

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb
	import shic_pkg::*;
;
	logic sys_clk, reset, reg_wr, reg_rd, halt_instr, go, rd_taken, pul_prev;
	logic [SHIC_ADDR_W-1:0] reg_addr;
	logic [SHIC_DATA_W-1:0] reg_wdata, reg_rdata;
	logic subclock_fitted, tmr_m_sel_subclock, watch_sel_baud_divider;
	logic port_hold, data_retain, ack_nmi, ack_maskable, resume_next, sys_reset_req, in_halt, in_idle1;
	logic [1:0] delay;
	logic [7:0] pv;
	shic_wake_src_t wake_src, want_src, ms;
	shic_rst_src_t rst_src, want_rst;
	shic_isr_t isr;
	shic_clk_en_t clk_en;
	logic [7:0] rq[$];
	logic [7:0] wq[$];
	int error_cnt = 0;
	int tests_run = 0;
	int seed = 74380;

	shic_top dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .halt_instr, .wake_src,
		.isr, .rst_src, .subclock_fitted, .tmr_m_sel_subclock, .watch_sel_baud_divider, .clk_en, .port_hold,
		.data_retain, .ack_nmi, .ack_maskable, .resume_next, .sys_reset_req, .in_halt, .in_idle1);
	shic_partner partner (.sys_clk, .reset, .go, .delay, .want_src, .want_rst,
		.woke(ack_nmi | ack_maskable | resume_next | sys_reset_req), .wake_src, .rst_src);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ========================================================
	// Checking
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out;
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	always @(posedge sys_clk) begin
		rd_taken = reg_rd;
		#1;
		if (rd_taken) chk(reg_rdata, rq.size() > 0 ? rq.pop_front() : 8'hEE);
		pv = {2'h0, ack_nmi, ack_maskable, resume_next, sys_reset_req, in_halt, in_idle1};
		if (|pv[5:2] && !pul_prev) chk(pv, wq.size() > 0 ? wq.pop_front() : 8'hEE);
		pul_prev = |pv[5:2];
	end

	// ========================================================
	// Drivers
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(exp);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic raise(input shic_wake_src_t s, input shic_rst_src_t r);
		@(posedge sys_clk);
		want_src <= s;
		want_rst <= r;
		delay <= 2'($random(seed));
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask : raise

	task automatic wait_for(input logic [1:0] m);
		int n;
		n = 0;
		#1;
		while ({in_halt, in_idle1} !== m) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n > 20) begin
				error_cnt++;
				close_out();
			end
		end
	endtask : wait_for

	// Enter halt or idle-1, check the held state, then wake by source kind k
	task automatic trip(input bit idle, input int k);
		shic_wake_src_t s;
		shic_rst_src_t r;
		logic ackm, f, ts, wt;
		s = '0;
		r = '0;
		@(posedge sys_clk);
		isr <= shic_isr_t'(5'($random(seed)));
		{subclock_fitted, tmr_m_sel_subclock, watch_sel_baud_divider} <= 3'($random(seed));
		if (idle) begin
			wr(SHIC_SAVE_CTL_OFF, 8'h02);
		end else begin
			halt_instr <= 1'b1;
			@(posedge sys_clk);
			halt_instr <= 1'b0;
		end
		wait_for({!idle, idle});
		f = subclock_fitted;
		ts = tmr_m_sel_subclock;
		wt = subclock_fitted | watch_sel_baud_divider;
		chk({clk_en.cpu, clk_en.periph, port_hold, data_retain, clk_en.main_osc, clk_en.pll,
			clk_en.general_timer_m, clk_en.watch_timer}, {1'b0, !idle, 4'hF, idle ? f & ts : f | !ts, wt});
		if (idle) chk({6'h0, clk_en.sub_ext_periph, clk_en.flash}, 8'h03);
		rd(SHIC_STAT_OFF, idle ? 8'h02 : 8'h09);
		s.int_req_prio = 3'($random(seed));
		case (k)
			0: s.nmi_pin = 1'b1;
			1: s.watchdog_interrupt = 1'b1;
			2: s.external_interrupt_pins = 15'h0001 << ($unsigned($random(seed)) % 15);
			3: s.periph_int_req = 1'b1;
			default: r = shic_rst_src_t'(5'h01 << ($unsigned($random(seed)) % 5));
		endcase
		ackm = isr.interrupts_enabled_state && (!isr.in_service || s.int_req_prio < isr.service_prio);
		wq.push_back(k < 2 ? 8'h20 : k > 3 ? 8'h04 : ackm ? 8'h10 : 8'h08);
		raise(s, r);
		wait_for(2'h0);
		if (idle) rd(SHIC_SAVE_CTL_OFF, 8'h00);
	endtask : trip

	// ========================================================
	// Main sequence
	initial begin
		reset = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		halt_instr = 1'b0;
		go = 1'b0;
		delay = 2'h0;
		want_src = '0;
		want_rst = '0;
		isr = '0;
		pul_prev = 1'b0;
		{subclock_fitted, tmr_m_sel_subclock, watch_sel_baud_divider} = 3'h0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		rd(SHIC_SAVE_CTL_OFF, 8'h00);
		rd(SHIC_MODE_SEL_OFF, 8'h00);
		rd(SHIC_STAT_OFF, 8'h0C);
		rd(4'hF, 8'h00);
		wr(SHIC_SAVE_CTL_OFF, 8'h70);
		rd(SHIC_SAVE_CTL_OFF, 8'h70);
		for (int i = 0; i < 15; i++) trip(1'b0, i % 5);
		wr(SHIC_SAVE_CTL_OFF, 8'h00);
		for (int i = 0; i < 15; i++) trip(1'b1, i % 5);
		for (int b = 0; b < 3; b++) begin
			ms = '0;
			if (b == 0) ms.external_interrupt_pins = 15'h4000;
			else if (b == 1) ms.nmi_pin = 1'b1;
			else ms.watchdog_interrupt = 1'b1;
			wr(SHIC_SAVE_CTL_OFF, 8'h10 << b);
			wr(SHIC_SAVE_CTL_OFF, (8'h10 << b) | 8'h02);
			wait_for(2'h1);
			raise(ms, '0);
			repeat (6) @(posedge sys_clk);
			#1;
			chk({6'h0, in_halt, in_idle1}, 8'h01);
			wq.push_back(8'h04);
			raise(ms, shic_rst_src_t'(5'h10));
			wait_for(2'h0);
		end
		wr(SHIC_SAVE_CTL_OFF, 8'h00);
		ms = '0;
		ms.periph_int_req = 1'b1;
		@(posedge sys_clk);
		isr <= '0;
		raise(ms, '0);
		repeat (2) @(posedge sys_clk);
		wq.push_back(8'h08);
		wr(SHIC_SAVE_CTL_OFF, 8'h02);
		repeat (4) @(posedge sys_clk);
		wr(SHIC_MODE_SEL_OFF, 8'h01);
		wr(SHIC_SAVE_CTL_OFF, 8'h02);
		repeat (3) @(posedge sys_clk);
		#1;
		chk({6'h0, in_halt, in_idle1}, 8'h00);
		rd(SHIC_SAVE_CTL_OFF, 8'h00);
		rd(SHIC_MODE_SEL_OFF, 8'h01);
		repeat (4) @(posedge sys_clk);
		if (rq.size() + wq.size() != 0) error_cnt++;
		close_out();
	end
endmodule : tb
